// file: shared/sfg_pkg.sv
package sfg_pkg;

	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_PS = 4000;
	localparam int TICK_TIME_NS  = 100000;
	localparam int TICK_CYCLES   = TICK_TIME_NS * 1000 / CLK_PERIOD_PS;
	localparam logic [13:0] MIN_FREQ_HZ = 14'h0001;
	localparam logic [13:0] MAX_FREQ_HZ = 14'h2710;
	// Phase step per Hz is 2^42 / 250 MHz, used with a 10-bit right shift
	localparam logic [14:0] PHASE_INC_MUL = 15'h44b8;
	localparam int PHASE_INC_SHIFT = 10;

	// ****************************************
	// Register map
	// ****************************************
	localparam logic [7:0] ADDR_CTRL    = 8'h00;
	localparam logic [7:0] ADDR_MODE    = 8'h04;
	localparam logic [7:0] ADDR_STATUS  = 8'h08;
	localparam logic [7:0] ADDR_AMPL    = 8'h0c;
	localparam logic [7:0] ADDR_OFFS    = 8'h10;
	localparam logic [7:0] ADDR_FREQ    = 8'h14;
	localparam logic [7:0] ADDR_IVL0    = 8'h18;
	localparam logic [7:0] ADDR_IVL_END = 8'h28;
	localparam logic [7:0] ADDR_CYCLES  = 8'h28;
	localparam logic [7:0] ADDR_PAUSE   = 8'h2c;
	localparam logic [7:0] ADDR_STAT_U  = 8'h30;
	localparam logic [7:0] ADDR_STAT_I  = 8'h34;
	localparam logic [7:0] ADDR_SEG     = 8'h40;
	localparam logic [7:0] ADDR_SEG_END = 8'h68;

	// ****************************************
	// Fields
	// ****************************************
	localparam int CTRL_LOAD   = 0;
	localparam int CTRL_START  = 1;
	localparam int CTRL_STOP   = 2;
	localparam int CTRL_TOGGLE = 3;
	localparam int CTRL_CLEAR  = 4;
	localparam int MODE_TGT_I  = 4;
	localparam int LVL_END_LSB = 16;
	localparam int STAT_ST_LSB    = 0;
	localparam int STAT_PHASE_LSB = 2;
	localparam int STAT_OUT       = 5;
	localparam int STAT_ALARM     = 6;
	localparam int STAT_REJECT    = 7;
	localparam int STAT_GEN_LSB   = 16;
	localparam logic [11:0] FULL_SCALE = 12'hfff;

	// ****************************************
	// Reset values
	// ****************************************
	localparam logic [13:0] RST_FREQ   = 14'h0001;
	localparam logic [31:0] RST_IVL    = 32'h0000_0001;
	localparam logic [9:0]  RST_CYCLES = 10'h001;
	localparam logic [31:0] RST_PAUSE  = 32'h0000_2710;
	// Start level in [11:0], end level in [23:12], per engine-start segment
	localparam logic [4:0][23:0] SEG_DEF_LVL = {
		24'h9ff_9ff, 24'h9ff_7ff, 24'h7ff_7ff, 24'h7ff_5ff, 24'h5ff_9ff};
	localparam logic [4:0][31:0] SEG_DEF_TIME = {
		32'h0000_03e8, 32'h0000_2710, 32'h0000_07d0, 32'h0000_0032,
		32'h0000_0096};

	typedef enum logic [2:0] {WAVE_SINE, WAVE_TRI, WAVE_RECT, WAVE_TRAP,
		WAVE_ENGINE} sfg_wave_type;
	typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_READY, ST_RUN} sfg_state_type;

endpackage : sfg_pkg

// file: shared/sfg_timer_if.sv
`timescale 1ns/1ps
interface sfg_timer_if;
	logic        tick;
	logic        start;
	logic [31:0] len;
	logic        done;
	modport ctl (output tick, output start, output len, input done);
	modport tmr (input tick, input start, input len, output done);
endinterface : sfg_timer_if

// file: logic/sfg_interval_timer.sv
`timescale 1ns/1ps
module sfg_interval_timer (
	input wire logic core_clk,
	input wire logic rstn,
	sfg_timer_if.tmr tim
);
	typedef struct packed {
		logic        busy;
		logic [31:0] left;
		logic        done;
	} sfg_timer_state_type;

	sfg_timer_state_type r;
	sfg_timer_state_type n;

	// A length of zero behaves as one tick, so a phase never stalls
	always_comb
	begin
		n = r;
		n.done = 1'b0;
		if (tim.start)
		begin
			n.busy = 1'b1;
			n.left = tim.len;
		end
		else if (r.busy && tim.tick)
		begin
			if (r.left <= 32'h0000_0001)
			begin
				n.busy = 1'b0;
				n.done = 1'b1;
			end
			else
				n.left = r.left - 32'h0000_0001;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
			r <= '0;
		else
			r <= n;
	end

	assign tim.done = r.done;
endmodule : sfg_interval_timer

// file: logic/sfg_sine_lut.sv
`timescale 1ns/1ps
module sfg_sine_lut (
	input  wire logic        [5:0]  phase,
	output logic signed      [11:0] sine
);
	logic [10:0] mag;
	logic [3:0]  idx;

	// Quarter wave, 16 points sampled at mid-step so the mirror is exact
	always_comb
	begin
		idx = phase[4] ? ~phase[3:0] : phase[3:0];
		case (idx)
			4'h0: mag = 11'h064;
			4'h1: mag = 11'h12c;
			4'h2: mag = 11'h1f1;
			4'h3: mag = 11'h2b2;
			4'h4: mag = 11'h36b;
			4'h5: mag = 11'h41c;
			4'h6: mag = 11'h4c3;
			4'h7: mag = 11'h55f;
			4'h8: mag = 11'h5ed;
			4'h9: mag = 11'h66c;
			4'ha: mag = 11'h6dc;
			4'hb: mag = 11'h73b;
			4'hc: mag = 11'h787;
			4'hd: mag = 11'h7c2;
			4'he: mag = 11'h7e9;
			default: mag = 11'h7fd;
		endcase
		sine = phase[5] ? -$signed({1'b0, mag}) : $signed({1'b0, mag});
	end
endmodule : sfg_sine_lut

// file: logic/sfg_core.sv
//
// Overview of operation
// - Load, apply static values, output on, allow start
// - Current waveform starts from zero amperes
// - Start begins generation; toggle-on only switches output on
// - Stop halts waveform, output stays on static
// - Toggle during run halts and disables output
// - Alarm or trip halts, disables output, reports
// - Sine offset not below amplitude; reject violations
// - Sine frequency fixed, 1 Hz to 10 kHz
// - Sine equals offset plus amplitude times sine
// - Triangle rises then falls over two intervals
// - Triangle period is rise plus fall interval
// - Triangle foot is offset, peak offset plus amplitude
// - Rectangle holds top then offset, then repeats
// - Rectangle low is offset, high adds amplitude
// - Trapezoid rises, holds top, falls, holds base
// - Trapezoid base is offset, top adds amplitude
// - Engine curve drives voltage only, five segments
// - Each segment ramps linearly start to end
// - Engine curve repeats endlessly or 1 to 999 (the 10-bit cycle count accepts up to 1023)
// - Pause after each cycle except the last of a counted run
// - Segments preload standard curve at reset
// - Set value has 4096 steps, voltage run starts at static value
// - Mode and parameters change only with output off
// - Waveform drives one set value, others static
//
`timescale 1ns/1ps
module sfg_core #(
	parameter int TICK_CYC = sfg_pkg::TICK_CYCLES
) (
	input  wire logic        core_clk,
	input  wire logic        rstn,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	input  wire logic        on_off_button,
	input  wire logic        device_alarm,
	input  wire logic        overpower_trip,
	input  wire logic        overcurrent_trip,
	input  wire logic        event_alarm,
	output logic      [11:0] voltage_setpoint,
	output logic      [11:0] current_setpoint,
	output logic             dc_output_on,
	output logic             alarm_report,
	output logic             start_enabled
);
	localparam logic [14:0] TICK_LAST = 15'(TICK_CYC - 1);

	typedef struct packed {
		logic [4:0]               sync1;
		logic [4:0]               sync2;
		logic                     btn_prev;
		sfg_pkg::sfg_state_type   st;
		logic                     out_on;
		logic                     alarm;
		logic                     reject;
		sfg_pkg::sfg_wave_type    wave;
		logic                     tgt_i;
		logic [11:0]              amp;
		logic [11:0]              offs;
		logic [13:0]              freq;
		logic [3:0][31:0]         ivl;
		logic [9:0]               cycles;
		logic [31:0]              pause;
		logic [11:0]              stat_u;
		logic [11:0]              stat_i;
		logic [4:0][23:0]         seg_lvl;
		logic [4:0][31:0]         seg_time;
		logic [14:0]              div;
		logic                     tick;
		logic [2:0]               phase;
		logic                     arm;
		logic [9:0]               cyc_cnt;
		logic [31:0]              acc;
		logic [11:0]              from;
		logic                     down;
		logic [11:0]              dmag;
		logic [43:0]              num;
		logic [43:0]              thr;
		logic [31:0]              len;
		logic [11:0]              steps;
		logic [11:0]              gen;
		logic                     tstart;
		logic [31:0]              tlen;
		logic [11:0]              vset;
		logic [11:0]              iset;
		logic [31:0]              rdata;
	} sfg_core_state_type;

	sfg_core_state_type r;
	sfg_core_state_type n;

	logic [4:0]         cmd;
	logic               alarm_evt;
	logic               toggle_evt;
	logic               bad;
	logic [12:0]        sum13;
	logic [11:0]        lo;
	logic [11:0]        hi;
	logic [1:0]         ep;
	logic [2:0]         sidx;
	logic [2:0]         nph;
	logic [11:0]        wfrom;
	logic [11:0]        wto;
	logic [31:0]        wlen;
	logic [7:0]         woff;
	logic [28:0]        incw;
	logic signed [11:0] sine;
	logic signed [24:0] sprod;
	logic signed [13:0] sval;

	sfg_timer_if tif ();

	sfg_interval_timer u_timer (
		.core_clk (core_clk),
		.rstn     (rstn),
		.tim      (tif.tmr)
	);

	sfg_sine_lut u_sine (
		.phase (r.acc[31:26]),
		.sine  (sine)
	);

	assign tif.tick  = r.tick;
	assign tif.start = r.tstart;
	assign tif.len   = r.tlen;

	always_comb
	begin
		n = r;
		n.sync1 = {device_alarm, overpower_trip, overcurrent_trip, event_alarm,
			on_off_button};
		n.sync2 = r.sync1;
		n.btn_prev = r.sync2[0];
		n.tstart = 1'b0;
		n.rdata = '0;
		cmd = (reg_wr && reg_addr == sfg_pkg::ADDR_CTRL) ? reg_wdata[4:0] : 5'h00;
		alarm_evt = |r.sync2[4:1];
		toggle_evt = cmd[sfg_pkg::CTRL_TOGGLE] || (r.sync2[0] && !r.btn_prev);
		sum13 = {1'b0, r.amp} + {1'b0, r.offs};
		lo = r.offs;
		hi = sum13[11:0];
		bad = sum13[12] || (r.wave == sfg_pkg::WAVE_SINE && r.offs < r.amp)
			|| r.freq < sfg_pkg::MIN_FREQ_HZ || r.freq > sfg_pkg::MAX_FREQ_HZ
			|| r.wave > sfg_pkg::WAVE_ENGINE;
		woff = reg_addr - sfg_pkg::ADDR_SEG;
		sidx = (r.phase < 3'h5) ? r.phase : 3'h0;
		nph = (r.wave == sfg_pkg::WAVE_TRAP) ? 3'h4 : 3'h2;
		incw = r.freq * sfg_pkg::PHASE_INC_MUL;
		sprod = $signed({1'b0, r.amp}) * sine;
		sval = $signed({2'b00, r.offs}) + sprod[24:11];

		// ****************************************
		// Time base
		// ****************************************
		n.tick = 1'b0;
		if (r.div == TICK_LAST)
		begin
			n.div = '0;
			n.tick = 1'b1;
		end
		else
			n.div = r.div + 15'h0001;

		// ****************************************
		// Register access
		// ****************************************
		// Parameter writes are dropped while the output is live
		if (reg_wr && !r.out_on)
		begin
			case (reg_addr)
				sfg_pkg::ADDR_MODE:
				begin
					n.wave = sfg_pkg::sfg_wave_type'(reg_wdata[2:0]);
					n.tgt_i = reg_wdata[sfg_pkg::MODE_TGT_I];
				end
				sfg_pkg::ADDR_AMPL:   n.amp = reg_wdata[11:0];
				sfg_pkg::ADDR_OFFS:   n.offs = reg_wdata[11:0];
				sfg_pkg::ADDR_FREQ:   n.freq = reg_wdata[13:0];
				sfg_pkg::ADDR_CYCLES: n.cycles = reg_wdata[9:0];
				sfg_pkg::ADDR_PAUSE:  n.pause = reg_wdata;
				sfg_pkg::ADDR_STAT_U: n.stat_u = reg_wdata[11:0];
				sfg_pkg::ADDR_STAT_I: n.stat_i = reg_wdata[11:0];
				default:
				begin
					if (reg_addr >= sfg_pkg::ADDR_IVL0 && reg_addr < sfg_pkg::ADDR_IVL_END)
						n.ivl[2'(reg_addr - sfg_pkg::ADDR_IVL0 >> 2)] = reg_wdata;
					else if (reg_addr >= sfg_pkg::ADDR_SEG
						&& reg_addr < sfg_pkg::ADDR_SEG_END)
					begin
						if (woff[2])
							n.seg_time[3'(woff >> 3)] = reg_wdata;
						else
							n.seg_lvl[3'(woff >> 3)] = {
								reg_wdata[sfg_pkg::LVL_END_LSB+:12], reg_wdata[11:0]};
					end
				end
			endcase
		end

		if (reg_rd)
		begin
			case (reg_addr)
				sfg_pkg::ADDR_STATUS:
				begin
					n.rdata[sfg_pkg::STAT_ST_LSB+:2] = r.st;
					n.rdata[sfg_pkg::STAT_PHASE_LSB+:3] = r.phase;
					n.rdata[sfg_pkg::STAT_OUT] = r.out_on;
					n.rdata[sfg_pkg::STAT_ALARM] = r.alarm;
					n.rdata[sfg_pkg::STAT_REJECT] = r.reject;
					n.rdata[sfg_pkg::STAT_GEN_LSB+:12] = r.gen;
				end
				sfg_pkg::ADDR_MODE:
				begin
					n.rdata[2:0] = r.wave;
					n.rdata[sfg_pkg::MODE_TGT_I] = r.tgt_i;
				end
				sfg_pkg::ADDR_AMPL:   n.rdata[11:0] = r.amp;
				sfg_pkg::ADDR_OFFS:   n.rdata[11:0] = r.offs;
				sfg_pkg::ADDR_FREQ:   n.rdata[13:0] = r.freq;
				sfg_pkg::ADDR_CYCLES: n.rdata[9:0] = r.cycles;
				sfg_pkg::ADDR_PAUSE:  n.rdata = r.pause;
				sfg_pkg::ADDR_STAT_U: n.rdata[11:0] = r.stat_u;
				sfg_pkg::ADDR_STAT_I: n.rdata[11:0] = r.stat_i;
				default:
				begin
					if (reg_addr >= sfg_pkg::ADDR_IVL0 && reg_addr < sfg_pkg::ADDR_IVL_END)
						n.rdata = r.ivl[2'(reg_addr - sfg_pkg::ADDR_IVL0 >> 2)];
					else if (reg_addr >= sfg_pkg::ADDR_SEG
						&& reg_addr < sfg_pkg::ADDR_SEG_END)
					begin
						if (woff[2])
							n.rdata = r.seg_time[3'(woff >> 3)];
						else
						begin
							n.rdata[11:0] = r.seg_lvl[3'(woff >> 3)][11:0];
							n.rdata[sfg_pkg::LVL_END_LSB+:12] = r.seg_lvl[3'(woff >> 3)][23:12];
						end
					end
				end
			endcase
		end

		// ****************************************
		// Waveform engine
		// ****************************************
		unique case (r.wave)
			sfg_pkg::WAVE_TRI:  ep = (r.phase == 3'h0) ? 2'h0 : 2'h2;
			sfg_pkg::WAVE_RECT: ep = (r.phase == 3'h0) ? 2'h1 : 2'h3;
			sfg_pkg::WAVE_TRAP: ep = r.phase[1:0];
			default:            ep = 2'h0;
		endcase
		wfrom = (ep == 2'h1 || ep == 2'h2) ? hi : lo;
		wto = (ep == 2'h0 || ep == 2'h1) ? hi : lo;
		wlen = r.ivl[r.phase[1:0]];
		if (r.wave == sfg_pkg::WAVE_ENGINE)
		begin
			if (r.phase < 3'h5)
			begin
				wfrom = r.seg_lvl[sidx][11:0];
				wto = r.seg_lvl[sidx][23:12];
				wlen = r.seg_time[sidx];
			end
			else
			begin
				wfrom = r.gen;
				wto = r.gen;
				wlen = r.pause;
			end
		end

		if (r.st == sfg_pkg::ST_RUN)
		begin
			if (r.wave == sfg_pkg::WAVE_SINE)
			begin
				n.acc = r.acc + {13'h0000, incw[28:sfg_pkg::PHASE_INC_SHIFT]};
				if (sval < 0)
					n.gen = '0;
				else if (sval > $signed({2'b00, sfg_pkg::FULL_SCALE}))
					n.gen = sfg_pkg::FULL_SCALE;
				else
					n.gen = sval[11:0];
			end
			else if (r.arm)
			begin
				n.arm = 1'b0;
				n.from = wfrom;
				n.down = wto < wfrom;
				n.dmag = (wto < wfrom) ? wfrom - wto : wto - wfrom;
				n.num = '0;
				n.thr = {12'h000, wlen};
				n.len = wlen;
				n.steps = '0;
				n.gen = wfrom;
				n.tstart = 1'b1;
				n.tlen = wlen;
			end
			else
			begin
				// Spreads the step count evenly over the interval
				if (r.tick)
					n.num = r.num + {32'h0, r.dmag};
				if (r.num >= r.thr && r.steps != r.dmag)
				begin
					n.steps = r.steps + 12'h001;
					n.thr = r.thr + {12'h000, r.len};
				end
				n.gen = r.down ? r.from - r.steps : r.from + r.steps;
				if (tif.done)
				begin
					n.gen = r.down ? r.from - r.dmag : r.from + r.dmag;
					n.arm = 1'b1;
					if (r.wave == sfg_pkg::WAVE_ENGINE)
					begin
						if (r.phase < 3'h4)
							n.phase = r.phase + 3'h1;
						else if (r.phase == 3'h4)
						begin
							n.cyc_cnt = r.cyc_cnt + 10'h001;
							if (r.cycles != 10'h000 && r.cyc_cnt + 10'h001 == r.cycles)
							begin
								n.st = sfg_pkg::ST_IDLE;
								n.arm = 1'b0;
							end
							else
								n.phase = 3'h5;
						end
						else
							n.phase = 3'h0;
					end
					else
						n.phase = (r.phase == nph - 3'h1) ? 3'h0 : r.phase + 3'h1;
				end
			end
		end

		// ****************************************
		// Control sequence
		// ****************************************
		if (r.st == sfg_pkg::ST_LOAD)
		begin
			n.out_on = 1'b1;
			n.st = sfg_pkg::ST_READY;
		end
		if (cmd[sfg_pkg::CTRL_CLEAR])
		begin
			n.alarm = 1'b0;
			n.reject = 1'b0;
		end
		if (alarm_evt)
		begin
			n.st = sfg_pkg::ST_IDLE;
			n.out_on = 1'b0;
			n.alarm = 1'b1;
		end
		else if (toggle_evt && r.out_on)
		begin
			n.st = sfg_pkg::ST_IDLE;
			n.out_on = 1'b0;
		end
		else if (cmd[sfg_pkg::CTRL_STOP] && r.st == sfg_pkg::ST_RUN)
			n.st = sfg_pkg::ST_IDLE;
		else if ((cmd[sfg_pkg::CTRL_START] || toggle_evt) && r.st == sfg_pkg::ST_READY)
		begin
			n.st = sfg_pkg::ST_RUN;
			n.out_on = 1'b1;
			n.phase = '0;
			n.arm = 1'b1;
			n.acc = '0;
			n.cyc_cnt = '0;
			n.gen = (r.tgt_i && r.wave != sfg_pkg::WAVE_ENGINE) ? 12'h000 : r.stat_u;
		end
		else if (toggle_evt)
			n.out_on = 1'b1;
		else if (cmd[sfg_pkg::CTRL_LOAD])
		begin
			if (r.st == sfg_pkg::ST_IDLE && !bad)
				n.st = sfg_pkg::ST_LOAD;
			else
				n.reject = 1'b1;
		end

		// ****************************************
		// Set value routing
		// ****************************************
		n.vset = r.stat_u;
		n.iset = (r.tgt_i && r.wave != sfg_pkg::WAVE_ENGINE) ? 12'h000 : r.stat_i;
		if (n.st == sfg_pkg::ST_RUN)
		begin
			if (r.tgt_i && r.wave != sfg_pkg::WAVE_ENGINE)
				n.iset = n.gen;
			else
				n.vset = n.gen;
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!rstn)
		begin
			r <= '0;
			r.freq <= sfg_pkg::RST_FREQ;
			r.ivl <= {4{sfg_pkg::RST_IVL}};
			r.cycles <= sfg_pkg::RST_CYCLES;
			r.pause <= sfg_pkg::RST_PAUSE;
			r.seg_lvl <= sfg_pkg::SEG_DEF_LVL;
			r.seg_time <= sfg_pkg::SEG_DEF_TIME;
		end
		else
			r <= n;
	end

	assign reg_rdata = r.rdata;
	assign voltage_setpoint = r.vset;
	assign current_setpoint = r.iset;
	assign dc_output_on = r.out_on;
	assign alarm_report = r.alarm;
	assign start_enabled = (r.st == sfg_pkg::ST_READY);

	// ****************************************
	// Checks
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rstn);

	load_then_ready_a:
	assert property (r.st == sfg_pkg::ST_LOAD && !alarm_evt |=> r.out_on
		&& r.st == sfg_pkg::ST_READY)
	else $error("load did not enable output and start");

	start_runs_a:
	assert property (cmd[sfg_pkg::CTRL_START] && r.st == sfg_pkg::ST_READY
		&& !alarm_evt && !toggle_evt |=> r.st == sfg_pkg::ST_RUN && r.out_on)
	else $error("start did not begin generation");

	stop_keeps_on_a:
	assert property (cmd[sfg_pkg::CTRL_STOP] && r.st == sfg_pkg::ST_RUN
		&& !alarm_evt && !toggle_evt |=> r.st == sfg_pkg::ST_IDLE && r.out_on
		##1 voltage_setpoint == r.stat_u)
	else $error("stop changed output state");

	toggle_off_a:
	assert property (toggle_evt && r.out_on && !alarm_evt |=> !dc_output_on
		&& r.st == sfg_pkg::ST_IDLE)
	else $error("toggle did not switch output off");

	alarm_abort_a:
	assert property (alarm_evt |=> !dc_output_on && alarm_report
		&& r.st == sfg_pkg::ST_IDLE)
	else $error("alarm did not abort");

	sine_reject_a:
	assert property (cmd[sfg_pkg::CTRL_LOAD] && r.wave == sfg_pkg::WAVE_SINE
		&& r.offs < r.amp && !alarm_evt && !toggle_evt
		&& !cmd[sfg_pkg::CTRL_START] && !cmd[sfg_pkg::CTRL_STOP]
		|=> r.reject && r.st != sfg_pkg::ST_LOAD)
	else $error("bad sine setting accepted");

	engine_volt_a:
	assert property (r.st == sfg_pkg::ST_RUN && r.wave == sfg_pkg::WAVE_ENGINE
		|-> current_setpoint == r.stat_i)
	else $error("engine curve touched current");

	idle_zero_i_a:
	assert property (r.st == sfg_pkg::ST_READY && r.tgt_i
		&& r.wave != sfg_pkg::WAVE_ENGINE |-> current_setpoint == 12'h000)
	else $error("current target not starting from zero");

	locked_mode_a:
	assert property (r.out_on && reg_wr && reg_addr == sfg_pkg::ADDR_MODE
		|=> $stable(r.wave) && $stable(r.tgt_i))
	else $error("mode changed with output on");

	ramp_ends_a:
	assert property (r.st == sfg_pkg::ST_RUN && !r.arm && tif.done
		&& r.wave != sfg_pkg::WAVE_SINE
		|=> r.gen == (($past(r.down)) ? $past(r.from) - $past(r.dmag)
		: $past(r.from) + $past(r.dmag)))
	else $error("ramp did not reach its end level");
endmodule : sfg_core

// file: dv/sfg_stage_model.sv
`timescale 1ns/1ps
// ****************************************
// Output stage stand-in
// ****************************************
module sfg_stage_model (
	input  wire logic        core_clk,
	input  wire logic [11:0] voltage_setpoint,
	input  wire logic        dc_output_on,
	input  wire logic        trip_req,
	output logic             overcurrent_trip
);
	logic [11:0] out_level;

	// A disabled stage cannot draw current, so it never trips and shows no level
	always_ff @(posedge core_clk)
	begin
		overcurrent_trip <= trip_req && dc_output_on;
		out_level        <= dc_output_on ? voltage_setpoint : 12'h000;
	end
endmodule : sfg_stage_model

// file: dv/testbench.sv
`timescale 1ns/1ps
module testbench;
	logic        core_clk;
	logic        rstn;
	logic [7:0]  reg_addr;
	logic [31:0] reg_wdata;
	logic        reg_wr;
	logic        reg_rd;
	logic [31:0] reg_rdata;
	logic        on_off_button;
	logic [3:0]  alm;
	logic        oc_trip;
	logic [11:0] voltage_setpoint;
	logic [11:0] current_setpoint;
	logic        dc_output_on;
	logic        alarm_report;
	logic        start_enabled;
	int          err_total;
	int          tests_run;
	int          cnt;
	int          t0;
	logic [31:0] d;
	logic [11:0] lo;
	logic [11:0] hi;
	logic        watch;
	logic        use_i;
	logic [11:0] bad_a [4] = '{12'h100, 12'h800, 12'h100, 12'h100};
	logic [11:0] bad_o [4] = '{12'h080, 12'h900, 12'h200, 12'h200};
	logic [13:0] bad_f [4] = '{14'h0001, 14'h0001, 14'h0000, 14'h2711};

	sfg_core #(.TICK_CYC(10)) u_sfg_core (.core_clk, .rstn, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .on_off_button, .device_alarm(alm[0]),
		.overpower_trip(alm[1]), .overcurrent_trip(oc_trip), .event_alarm(alm[3]),
		.voltage_setpoint, .current_setpoint, .dc_output_on, .alarm_report, .start_enabled);

	sfg_stage_model u_sfg_stage_model (.core_clk, .voltage_setpoint, .dc_output_on,
		.trip_req(alm[2]), .overcurrent_trip(oc_trip));

	initial
	begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// Extremes of the driven set value while watch is up
	always @(posedge core_clk)
	begin
		cnt <= cnt + 1;
		if (watch)
		begin
			lo <= (use_i ? current_setpoint : voltage_setpoint) < lo ?
				(use_i ? current_setpoint : voltage_setpoint) : lo;
			hi <= (use_i ? current_setpoint : voltage_setpoint) > hi ?
				(use_i ? current_setpoint : voltage_setpoint) : hi;
		end
	end

	// ****************************************
	// Access tasks
	// ****************************************
	task automatic conclude();
		if (err_total == 0 && tests_run > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : conclude

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", name, exp, seen);
		end
	endtask : chk

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask : cyc

	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge core_clk);
		reg_wr    <= 1'b1;
		reg_addr  <= a;
		reg_wdata <= v;
		@(posedge core_clk);
		reg_wr <= 1'b0;
	endtask : wr

	// Read data lives only in the cycle after the strobe
	task automatic rd(input logic [7:0] a);
		@(posedge core_clk);
		reg_rd   <= 1'b1;
		reg_addr <= a;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd

	task automatic ld(input logic [31:0] mode);
		wr(sfg_pkg::ADDR_MODE, mode);
		wr(sfg_pkg::ADDR_CTRL, 32'h0000_0001);
		cyc(3);
		chk("out_on", dc_output_on, 1);
		chk("start_en", start_enabled, 1);
	endtask : ld

	task automatic span(input int n);
		lo    = 12'hfff;
		hi    = 12'h000;
		watch <= 1'b1;
		cyc(n);
		watch <= 1'b0;
	endtask : span

	task automatic button();
		on_off_button <= 1'b1;
		cyc(5);
		chk("out_off", dc_output_on, 0);
		on_off_button <= 1'b0;
		cyc(3);
	endtask : button

	initial
	begin
		repeat (20000) @(posedge core_clk);
		err_total++;
		conclude();
	end

	// ****************************************
	// Scenarios
	// ****************************************
	initial
	begin
		{rstn, reg_addr, reg_wdata, reg_wr, reg_rd, on_off_button, alm} = '0;
		{watch, use_i, err_total, tests_run, cnt} = '0;
		repeat (8) @(posedge core_clk);
		rstn <= 1'b1;
		cyc(1);
		chk("rst_out", {dc_output_on, alarm_report, start_enabled}, 0);
		rd(sfg_pkg::ADDR_SEG);
		chk("seg0", d, {4'h0, sfg_pkg::SEG_DEF_LVL[0][23:12], 4'h0,
			sfg_pkg::SEG_DEF_LVL[0][11:0]});
		for (int i = 0; i < 4; i++)
		begin
			wr(sfg_pkg::ADDR_AMPL, {20'h0, bad_a[i]});
			wr(sfg_pkg::ADDR_OFFS, {20'h0, bad_o[i]});
			wr(sfg_pkg::ADDR_FREQ, {18'h0, bad_f[i]});
			wr(sfg_pkg::ADDR_MODE, 32'h0);
			wr(sfg_pkg::ADDR_CTRL, 32'h0000_0001);
			cyc(3);
			rd(sfg_pkg::ADDR_STATUS);
			chk("reject", d[sfg_pkg::STAT_REJECT], 1);
			chk("rej_off", dc_output_on, 0);
			wr(sfg_pkg::ADDR_CTRL, 32'h0000_0010);
		end
		wr(sfg_pkg::ADDR_AMPL, 32'h100);
		wr(sfg_pkg::ADDR_OFFS, 32'h200);
		wr(sfg_pkg::ADDR_FREQ, 32'h2710);
		wr(sfg_pkg::ADDR_STAT_U, 32'h3a0);
		wr(sfg_pkg::ADDR_STAT_I, 32'h123);
		ld(32'h0);
		wr(sfg_pkg::ADDR_MODE, 32'h2);
		rd(sfg_pkg::ADDR_MODE);
		chk("mode_lock", d[2:0], 0);
		wr(sfg_pkg::ADDR_CTRL, 32'h0000_0002);
		rd(sfg_pkg::ADDR_STATUS);
		chk("run", d[1:0], 3);
		wr(sfg_pkg::ADDR_CTRL, 32'h0000_0008);
		cyc(1);
		chk("tgl_off", dc_output_on, 0);
		for (int m = 1; m < 4; m++)
		begin
			ld(m);
			chk("static_u", voltage_setpoint, 12'h3a0);
			wr(sfg_pkg::ADDR_CTRL, 32'h0000_0002);
			cyc(5);
			span(150);
			chk("foot", lo, 12'h200);
			chk("peak", hi, 12'h300);
			wr(sfg_pkg::ADDR_CTRL, 32'h0000_0004);
			cyc(2);
			chk("stop_on", dc_output_on, 1);
			chk("stop_u", voltage_setpoint, 12'h3a0);
			rd(sfg_pkg::ADDR_STATUS);
			chk("stop_idle", d[1:0], 0);
			button();
		end
		ld(32'h11);
		chk("i_zero", current_setpoint, 0);
		use_i = 1'b1;
		wr(sfg_pkg::ADDR_CTRL, 32'h0000_0002);
		cyc(5);
		span(150);
		chk("i_span", {lo, hi}, {12'h200, 12'h300});
		chk("u_const", voltage_setpoint, 12'h3a0);
		button();
		use_i = 1'b0;
		for (int i = 0; i < 4; i++)
		begin
			ld(32'h2);
			wr(sfg_pkg::ADDR_CTRL, 32'h0000_0002);
			cyc(5);
			alm[i] <= 1'b1;
			cyc(5);
			chk("alm", {dc_output_on, alarm_report}, 2'b01);
			rd(sfg_pkg::ADDR_STATUS);
			chk("alm_idle", d[1:0], 0);
			alm[i] <= 1'b0;
			cyc(4);
			wr(sfg_pkg::ADDR_CTRL, 32'h0000_0010);
			cyc(2);
			chk("alm_clr", alarm_report, 0);
		end
		// Static start level inside the curve span, so the first run cycle stays in range
		wr(sfg_pkg::ADDR_STAT_U, 32'h7ff);
		wr(sfg_pkg::ADDR_CYCLES, 32'h2);
		// Three-tick pause keeps a missing pause apart from tick alignment slack
		wr(sfg_pkg::ADDR_PAUSE, 32'h3);
		for (int n = 0; n < 5; n++)
			wr(sfg_pkg::ADDR_SEG + 8'(8 * n + 4), 32'h1);
		ld(32'h4);
		wr(sfg_pkg::ADDR_CTRL, 32'h0000_0002);
		t0 = cnt;
		lo = 12'hfff;
		hi = 12'h000;
		watch <= 1'b1;
		for (int k = 0; k < 150; k++)
		begin
			rd(sfg_pkg::ADDR_STATUS);
			if (d[1:0] == 2'd0)
				break;
		end
		watch <= 1'b0;
		chk("eng_len", {31'h0, (cnt - t0) >= 120 && (cnt - t0) < 140}, 1);
		chk("eng_lvl", {lo, hi}, {12'h5ff, 12'h9ff});
		chk("eng_i", current_setpoint, 12'h123);
		chk("eng_on", dc_output_on, 1);
		conclude();
	end
endmodule : testbench
